// [hw/bfsl_pkg.sv]
package bfsl_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [11:0] BFSL_CFS_OFF   = 12'h000;
  localparam logic [11:0] BFSL_ADDR_OFF  = 12'h004;
  localparam logic [11:0] BFSL_SHCS_OFF  = 12'h008;
  localparam logic [11:0] BFSL_DBG_OFF   = 12'h00C;
  localparam logic [11:0] BFSL_STAT_OFF  = 12'h010;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BFSL_FIELD_LSB   = 8;
  localparam int BFSL_FETCH_BIT   = 8;
  localparam int BFSL_EXACT_BIT   = 9;
  localparam int BFSL_DEFER_BIT   = 10;
  localparam int BFSL_POP_BIT     = 11;
  localparam int BFSL_PUSH_BIT    = 12;
  localparam int BFSL_LAZY_BIT    = 13;
  localparam int BFSL_VALID_BIT   = 15;
  localparam int BFSL_ENA_BIT     = 17;
  localparam int BFSL_HALT_EN_BIT = 0;
  localparam int BFSL_CATCH_BUS_BIT = 8;
  localparam int BFSL_CATCH_INT_BIT = 10;

  localparam logic [7:0]  BFSL_FLAGS_RST = 8'h00;
  localparam logic [31:0] BFSL_ADDR_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    BFSL_SRC_FETCH,
    BFSL_SRC_DATA,
    BFSL_SRC_PUSH,
    BFSL_SRC_POP,
    BFSL_SRC_LAZY,
    BFSL_SRC_VECTOR
  } bfsl_src_t;

endpackage

// [hw/bfsl_classify.sv]
// ********************************************************************
// Error classification
// ********************************************************************
module bfsl_classify
  import bfsl_pkg::*;
(
  input  wire logic       err_valid_i,
  input  wire bfsl_src_t  err_src_i,
  input  wire logic       err_deferred_i,
  input  wire logic       fetch_used_i,
  input  wire logic       fpu_active_i,
  input  wire logic       ppb_unpriv_i,
  output logic [7:0]      cause_set_o,
  output logic            vector_err_o,
  output logic            async_o,
  output logic            sync_o
);

  logic is_data;
  logic data_err;

  // A privilege violation on the private bus is an ordinary data error.
  assign is_data  = err_valid_i && (err_src_i == BFSL_SRC_DATA);
  assign data_err = is_data || ppb_unpriv_i;

  // Discarded prefetches are dropped so that speculation never faults.
  always_comb begin
    cause_set_o = 8'h00;
    cause_set_o[BFSL_FETCH_BIT - BFSL_FIELD_LSB] =
      err_valid_i && (err_src_i == BFSL_SRC_FETCH) && fetch_used_i;
    cause_set_o[BFSL_EXACT_BIT - BFSL_FIELD_LSB] =
      data_err && !(is_data && err_deferred_i);
    cause_set_o[BFSL_DEFER_BIT - BFSL_FIELD_LSB] = is_data && err_deferred_i;
    cause_set_o[BFSL_POP_BIT - BFSL_FIELD_LSB] =
      err_valid_i && (err_src_i == BFSL_SRC_POP);
    cause_set_o[BFSL_PUSH_BIT - BFSL_FIELD_LSB] =
      err_valid_i && (err_src_i == BFSL_SRC_PUSH);
    cause_set_o[BFSL_LAZY_BIT - BFSL_FIELD_LSB] =
      err_valid_i && (err_src_i == BFSL_SRC_LAZY) && fpu_active_i;
  end

  assign vector_err_o = err_valid_i && (err_src_i == BFSL_SRC_VECTOR);
  assign async_o      = cause_set_o[BFSL_DEFER_BIT - BFSL_FIELD_LSB];
  assign sync_o       = |cause_set_o && !async_o;

endmodule

// [hw/bfsl_apb_regs.sv]
// ********************************************************************
// APB slave front end
// ********************************************************************
module bfsl_apb_regs
  import bfsl_pkg::*;
(
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             wr_cfs_o,
  output logic             wr_shcs_o,
  output logic             wr_dbg_o,
  output logic [3:0]       lane_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             hit_addr_o,
  output logic             hit_stat_o,
  output logic             hit_cfs_o,
  output logic             hit_shcs_o,
  output logic             hit_dbg_o
);

  logic access;
  logic mapped;

  assign access     = psel_i && penable_i;
  assign hit_cfs_o  = (paddr_i == BFSL_CFS_OFF);
  assign hit_addr_o = (paddr_i == BFSL_ADDR_OFF);
  assign hit_shcs_o = (paddr_i == BFSL_SHCS_OFF);
  assign hit_dbg_o  = (paddr_i == BFSL_DBG_OFF);
  assign hit_stat_o = (paddr_i == BFSL_STAT_OFF);
  assign mapped     = hit_cfs_o || hit_addr_o || hit_shcs_o || hit_dbg_o || hit_stat_o;

  // Zero wait states; unmapped addresses error out without side effects.
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;
  assign lane_o    = pstrb_i;
  assign wr_cfs_o  = access && pwrite_i && hit_cfs_o;
  assign wr_shcs_o = access && pwrite_i && hit_shcs_o;
  assign wr_dbg_o  = access && pwrite_i && hit_dbg_o;

endmodule

// [hw/bfsl_top.sv]
// ********************************************************************
// Bus fault status logic
// ********************************************************************
//
// Added by the designer: the register offsets and the APB interface to the registers.
module bfsl_top
  import bfsl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        err_valid_i,
  input  wire bfsl_src_t   err_src_i,
  input  wire logic        err_deferred_i,
  input  wire logic [31:0] err_addr_i,
  input  wire logic [31:0] err_pc_i,
  input  wire logic        fetch_used_i,
  input  wire logic        fpu_active_i,
  input  wire logic        ppb_unpriv_i,
  input  wire logic        can_take_i,
  input  wire logic        higher_pri_pending_i,
  input  wire logic        fault_taken_i,
  output logic             bus_fault_b_pend_o,
  output logic             hard_fault_a_pend_o,
  output logic             lockup_ok_o,
  output logic             take_bus_fault_o,
  output logic [31:0]      stacked_pc_o,
  output logic             debug_enter_o,
  output logic             ppb_bus_error_o
);

  // ********************************************************************
  // Decode and classification
  // ********************************************************************
  logic [7:0]  cause_set;
  logic        vector_err;
  logic        async_err;
  logic        sync_err;
  logic        wr_cfs;
  logic        wr_shcs;
  logic        wr_dbg;
  logic [3:0]  lane;
  logic        hit_addr;
  logic        hit_stat;
  logic        hit_cfs;
  logic        hit_shcs;
  logic        hit_dbg;

  bfsl_classify u_classify (
    .err_valid_i    (err_valid_i),
    .err_src_i      (err_src_i),
    .err_deferred_i (err_deferred_i),
    .fetch_used_i   (fetch_used_i),
    .fpu_active_i   (fpu_active_i),
    .ppb_unpriv_i   (ppb_unpriv_i),
    .cause_set_o    (cause_set),
    .vector_err_o   (vector_err),
    .async_o        (async_err),
    .sync_o         (sync_err)
  );

  bfsl_apb_regs u_regs (
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pstrb_i    (pstrb_i),
    .wr_cfs_o   (wr_cfs),
    .wr_shcs_o  (wr_shcs),
    .wr_dbg_o   (wr_dbg),
    .lane_o     (lane),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .hit_addr_o (hit_addr),
    .hit_stat_o (hit_stat),
    .hit_cfs_o  (hit_cfs),
    .hit_shcs_o (hit_shcs),
    .hit_dbg_o  (hit_dbg)
  );

  assign ppb_bus_error_o = ppb_unpriv_i;

  // ********************************************************************
  // Cause flags and fault address
  // ********************************************************************
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [7:0]  w1c_mask;
  logic [31:0] addr_reg;
  logic        valid_set;
  logic        valid_clr;
  logic        fault_addr_valid;

  // Bit 14 is reserved and bit 15 is handled apart, so only causes live here.
  // No cause marks a failed exclusive access; such a failure is not a fault.
  assign w1c_mask = (wr_cfs && lane[1]) ? pwdata_i[15:8] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      // A fresh event outranks a clear in the same cycle.
      assign flags_next[gi] = cause_set[gi] || (flags_reg[gi] && !w1c_mask[gi]);
    end
  endgenerate
  assign flags_next[7:6] = 2'b00;

  // A private bus privilege error carries no bus address; it leaves the address alone unless a non-data error is valid in the same cycle.
  assign valid_set = cause_set[BFSL_EXACT_BIT - BFSL_FIELD_LSB] && err_valid_i;
  assign valid_clr = w1c_mask[BFSL_VALID_BIT - BFSL_FIELD_LSB];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flags_reg <= BFSL_FLAGS_RST;
      fault_addr_valid <= 1'b0;
      addr_reg  <= BFSL_ADDR_RST;
    end else begin
      flags_reg <= flags_next;
      fault_addr_valid <= valid_set || (fault_addr_valid && !valid_clr);
      if (valid_set) begin
        addr_reg <= err_addr_i;
      end
    end
  end

  // ********************************************************************
  // Handler control and debug control
  // ********************************************************************
  logic bus_fault_enable;
  logic halt_en_reg;
  logic catch_bus_error;
  logic catch_internal_error;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_fault_enable     <= 1'b0;
      halt_en_reg          <= 1'b0;
      catch_bus_error      <= 1'b0;
      catch_internal_error <= 1'b0;
    end else begin
      if (wr_shcs && lane[2]) begin
        bus_fault_enable <= pwdata_i[BFSL_ENA_BIT];
      end
      if (wr_dbg && lane[0]) begin
        halt_en_reg <= pwdata_i[BFSL_HALT_EN_BIT];
      end
      if (wr_dbg && lane[1]) begin
        catch_bus_error      <= pwdata_i[BFSL_CATCH_BUS_BIT];
        catch_internal_error <= pwdata_i[BFSL_CATCH_INT_BIT];
      end
    end
  end

  // ********************************************************************
  // Pending, priority and hard fault fallback
  // ********************************************************************
  logic bus_pend_reg;
  logic hard_pend_reg;
  logic hard_async_reg;
  logic sync_to_bus;
  logic sync_to_hard;
  logic async_to_bus;
  logic async_to_hard;
  logic take_now;

  assign sync_to_bus   = sync_err && bus_fault_enable && can_take_i;
  assign sync_to_hard  = (sync_err && !(bus_fault_enable && can_take_i)) || vector_err;
  assign async_to_bus  = async_err && bus_fault_enable;
  assign async_to_hard = async_err && !bus_fault_enable;
  // A pending bus fault waits whenever a more urgent interrupt is in line.
  assign take_now      = bus_pend_reg && !higher_pri_pending_i;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_pend_reg   <= 1'b0;
      hard_pend_reg  <= 1'b0;
      hard_async_reg <= 1'b0;
    end else begin
      bus_pend_reg  <= sync_to_bus || async_to_bus || (bus_pend_reg && !(take_now && fault_taken_i));
      hard_pend_reg <= sync_to_hard || async_to_hard || (hard_pend_reg && !fault_taken_i);
      if (sync_to_hard) begin
        hard_async_reg <= 1'b0;
      end else if (async_to_hard) begin
        hard_async_reg <= 1'b1;
      end
    end
  end

  assign bus_fault_b_pend_o  = bus_pend_reg;
  assign hard_fault_a_pend_o = hard_pend_reg;
  assign take_bus_fault_o    = take_now;
  assign lockup_ok_o         = hard_pend_reg && !hard_async_reg;

  // ********************************************************************
  // Stacked return address and vector catch
  // ********************************************************************
  logic [31:0] pc_reg;
  logic        dbg_reg;
  logic        catch_hit;
  logic        bus_cause;
  logic        int_cause;

  // Only the catch bit that matches the cause may stop the core.
  assign bus_cause = |cause_set[BFSL_DEFER_BIT - BFSL_FIELD_LSB : BFSL_FETCH_BIT - BFSL_FIELD_LSB];
  assign int_cause = |cause_set[BFSL_LAZY_BIT - BFSL_FIELD_LSB : BFSL_POP_BIT - BFSL_FIELD_LSB];
  assign catch_hit = halt_en_reg &&
                     ((catch_bus_error && bus_cause) ||
                      (catch_internal_error && int_cause));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pc_reg  <= BFSL_ADDR_RST;
      dbg_reg <= 1'b0;
    end else begin
      if (cause_set[BFSL_EXACT_BIT - BFSL_FIELD_LSB] || cause_set[0]) begin
        pc_reg <= err_pc_i;
      end
      dbg_reg <= catch_hit;
    end
  end

  assign stacked_pc_o  = pc_reg;
  assign debug_enter_o = dbg_reg;

  // ********************************************************************
  // Read path
  // ********************************************************************
  logic [31:0] cfs_word;
  logic [31:0] shcs_word;
  logic [31:0] dbg_word;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  assign cfs_word  = {16'h0000, fault_addr_valid, 1'b0, flags_reg[5:0], 8'h00};
  assign shcs_word = {14'h0000, bus_fault_enable, 17'h00000};
  assign dbg_word  = {21'h000000, catch_internal_error, 1'b0, catch_bus_error,
                      7'h00, halt_en_reg};
  assign stat_word = {28'h0000000, hard_async_reg, hard_pend_reg, bus_pend_reg, dbg_reg};
  assign rd_mux    = hit_cfs  ? cfs_word  :
                     hit_addr ? addr_reg  :
                     hit_shcs ? shcs_word :
                     hit_dbg  ? dbg_word  :
                     hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

endmodule

// [testbench/bfsl_chk.sv]
module bfsl_chk
  import bfsl_pkg::*;
(
  input wire logic      sys_clk_i,
  input wire logic      srst_i,
  input wire logic      psel_i,
  input wire logic      penable_i,
  input wire logic      pready_o,
  input wire logic      err_valid_i,
  input wire bfsl_src_t err_src_i,
  input wire logic      err_deferred_i,
  input wire logic      fetch_used_i,
  input wire logic      can_take_i,
  input wire logic      higher_pri_pending_i,
  input wire logic      ppb_unpriv_i,
  input wire logic      bus_fault_b_pend_o,
  input wire logic      hard_fault_a_pend_o,
  input wire logic      lockup_ok_o,
  input wire logic      take_bus_fault_o,
  input wire logic      debug_enter_o,
  input wire logic      ppb_bus_error_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  wire logic async_ev;
  wire logic fetch_ev;
  assign async_ev = err_valid_i && err_src_i == BFSL_SRC_DATA && err_deferred_i;
  assign fetch_ev = err_valid_i && err_src_i == BFSL_SRC_FETCH;

  ppb_error_a: assert property (ppb_bus_error_o == ppb_unpriv_i)
    else $error("private bus error does not follow its cause");
  take_order_a: assert property (
    take_bus_fault_o |-> bus_fault_b_pend_o && !higher_pri_pending_i)
    else $error("bus fault taken ahead of a higher priority event");
  pend_hold_a: assert property (
    bus_fault_b_pend_o && higher_pri_pending_i |=> bus_fault_b_pend_o)
    else $error("pending bus fault dropped behind a higher priority event");
  vec_hard_a: assert property (
    err_valid_i && err_src_i == BFSL_SRC_VECTOR |=> hard_fault_a_pend_o)
    else $error("vector fetch error did not pend a hard fault");
  async_pend_a: assert property (
    async_ev |=> bus_fault_b_pend_o || hard_fault_a_pend_o)
    else $error("deferred data error was not pended");
  no_lockup_a: assert property (
    $past(async_ev) && $rose(hard_fault_a_pend_o) |-> !lockup_ok_o)
    else $error("asynchronous hard fault may reach lockup");
  sync_esc_a: assert property (
    fetch_ev && fetch_used_i && !can_take_i |=> hard_fault_a_pend_o)
    else $error("synchronous fault did not escalate");
  fetch_unused_a: assert property (
    fetch_ev && !fetch_used_i && !bus_fault_b_pend_o && !hard_fault_a_pend_o
    |=> !bus_fault_b_pend_o && !hard_fault_a_pend_o)
    else $error("unused fetch raised a fault");
  dbg_cause_a: assert property (
    debug_enter_o |-> $past(err_valid_i || ppb_unpriv_i) ##1 !debug_enter_o)
    else $error("debug entry without a fault or longer than one cycle");
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("register access not answered");

  cover property (take_bus_fault_o);
  cover property (hard_fault_a_pend_o && !lockup_ok_o);
  cover property (debug_enter_o);
endmodule

bind bfsl_top bfsl_chk u_chk (
  .sys_clk_i            (sys_clk_i),
  .srst_i               (srst_i),
  .psel_i               (psel_i),
  .penable_i            (penable_i),
  .pready_o             (pready_o),
  .err_valid_i          (err_valid_i),
  .err_src_i            (err_src_i),
  .err_deferred_i       (err_deferred_i),
  .fetch_used_i         (fetch_used_i),
  .can_take_i           (can_take_i),
  .higher_pri_pending_i (higher_pri_pending_i),
  .ppb_unpriv_i         (ppb_unpriv_i),
  .bus_fault_b_pend_o   (bus_fault_b_pend_o),
  .hard_fault_a_pend_o  (hard_fault_a_pend_o),
  .lockup_ok_o          (lockup_ok_o),
  .take_bus_fault_o     (take_bus_fault_o),
  .debug_enter_o        (debug_enter_o),
  .ppb_bus_error_o      (ppb_bus_error_o)
);

// [testbench/bfsl_resp_model.sv]
module bfsl_resp_model
  import bfsl_pkg::*;
(
  input  wire logic   sys_clk_i,
  output logic        err_valid_o,
  output bfsl_src_t   err_src_o,
  output logic        err_deferred_o,
  output logic [31:0] err_addr_o,
  output logic [31:0] err_pc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    err_valid_o = 1'b0;
    err_src_o = BFSL_SRC_FETCH;
    err_deferred_o = 1'b0;
    err_addr_o = 32'h0000_0000;
    err_pc_o = 32'hFFFF_FFFF;
  end

  // One-cycle error response. Once released the address lines flip, so a stale value never passes.
  task automatic hit(input bfsl_src_t s, input logic d, input logic [31:0] a);
    @(posedge sys_clk_i);
    err_valid_o <= 1'b1;
    err_src_o <= s;
    err_deferred_o <= d;
    err_addr_o <= a;
    err_pc_o <= ~a;
    @(posedge sys_clk_i);
    err_valid_o <= 1'b0;
    err_addr_o <= ~a;
    err_pc_o <= a;
  endtask
endmodule

// [testbench/bfsl_top_tb.sv]
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module bfsl_top_tb
  import bfsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, fetch_used_i = 1'b1, fpu_active_i = 1'b1, can_take_i = 1'b1;
  logic        ppb_unpriv_i = 1'b0, higher_pri_pending_i = 1'b0, fault_taken_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'h0;
  logic [31:0] prdata_o, stacked_pc_o, err_addr_i, err_pc_i, rd_q, a_q;
  logic        pready_o, pslverr_o, err_valid_i, err_deferred_i, err_q, dbg_seen = 1'b0;
  logic        bus_fault_b_pend_o, hard_fault_a_pend_o, lockup_ok_o, take_bus_fault_o;
  logic        debug_enter_o, ppb_bus_error_o;
  bfsl_src_t   err_src_i;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  bfsl_src_t   srcs [6] = '{BFSL_SRC_FETCH, BFSL_SRC_DATA, BFSL_SRC_DATA, BFSL_SRC_POP,
                            BFSL_SRC_PUSH, BFSL_SRC_LAZY};
  logic        defs [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [31:0] exps [6] = '{32'h0000_0100, 32'h0000_8200, 32'h0000_0400, 32'h0000_0800,
                            32'h0000_1000, 32'h0000_2000};

  bfsl_top u_dut (
    .sys_clk_i            (sys_clk_i),
    .srst_i               (srst_i),
    .psel_i               (psel_i),
    .penable_i            (penable_i),
    .pwrite_i             (pwrite_i),
    .paddr_i              (paddr_i),
    .pwdata_i             (pwdata_i),
    .pstrb_i              (pstrb_i),
    .prdata_o             (prdata_o),
    .pready_o             (pready_o),
    .pslverr_o            (pslverr_o),
    .err_valid_i          (err_valid_i),
    .err_src_i            (err_src_i),
    .err_deferred_i       (err_deferred_i),
    .err_addr_i           (err_addr_i),
    .err_pc_i             (err_pc_i),
    .fetch_used_i         (fetch_used_i),
    .fpu_active_i         (fpu_active_i),
    .ppb_unpriv_i         (ppb_unpriv_i),
    .can_take_i           (can_take_i),
    .higher_pri_pending_i (higher_pri_pending_i),
    .fault_taken_i        (fault_taken_i),
    .bus_fault_b_pend_o   (bus_fault_b_pend_o),
    .hard_fault_a_pend_o  (hard_fault_a_pend_o),
    .lockup_ok_o          (lockup_ok_o),
    .take_bus_fault_o     (take_bus_fault_o),
    .stacked_pc_o         (stacked_pc_o),
    .debug_enter_o        (debug_enter_o),
    .ppb_bus_error_o      (ppb_bus_error_o)
  );

  bfsl_resp_model u_resp (
    .sys_clk_i      (sys_clk_i),
    .err_valid_o    (err_valid_i),
    .err_src_o      (err_src_i),
    .err_deferred_o (err_deferred_i),
    .err_addr_o     (err_addr_i),
    .err_pc_o       (err_pc_i)
  );

  always #4 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cyc++;
    if (debug_enter_o === 1'b1) dbg_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ****
  // Access tasks
  // ****
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    if (n >= 64) miscompares++;
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic pend(input logic [2:0] e);
    apb(1'b0, BFSL_STAT_OFF, 32'h0, 4'h0);
    `CHK(rd_q[3:1], e)
  endtask

  task automatic tk();
    @(posedge sys_clk_i);
    fault_taken_i <= 1'b1;
    @(posedge sys_clk_i);
    fault_taken_i <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
    `CHK(rd_q, 32'h0000_0000)
    apb(1'b0, 12'h020, 32'h0, 4'h0);
    `CHK({err_q, rd_q}, 33'h1_0000_0000)
    apb(1'b1, BFSL_SHCS_OFF, 32'h0002_0000, 4'h4);
    apb(1'b0, BFSL_SHCS_OFF, 32'h0, 4'h0);
    `CHK(rd_q, 32'h0002_0000)
    apb(1'b1, BFSL_DBG_OFF, 32'h0000_0501, 4'h3);
    for (int i = 0; i < 6; i++) begin
      a_q = 32'hA000_0010 + i;
      u_resp.hit(srcs[i], defs[i], a_q);
      apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
      `CHK(rd_q, exps[i])
      if (i < 2) `CHK(stacked_pc_o, ~a_q)
      if (i == 1) begin
        apb(1'b0, BFSL_ADDR_OFF, 32'h0, 4'h0);
        `CHK(rd_q, a_q)
      end
      pend(3'b001);
      apb(1'b1, BFSL_CFS_OFF, 32'hFFFF_FFFF, 4'hD);
      apb(1'b1, BFSL_CFS_OFF, 32'h0000_0000, 4'hF);
      apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
      `CHK(rd_q, exps[i])
      apb(1'b1, BFSL_CFS_OFF, 32'h0000_FF00, 4'h2);
      apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
      `CHK(rd_q, 32'h0000_0000)
      tk();
      pend(3'b000);
    end
    `CHK(dbg_seen, 1'b1)
    fetch_used_i <= 1'b0;
    u_resp.hit(BFSL_SRC_FETCH, 1'b0, 32'h0000_0200);
    pend(3'b000);
    fetch_used_i <= 1'b1;
    fpu_active_i <= 1'b0;
    u_resp.hit(BFSL_SRC_LAZY, 1'b0, 32'h0000_0300);
    apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
    `CHK(rd_q, 32'h0000_0000)
    tk();
    u_resp.hit(BFSL_SRC_VECTOR, 1'b0, 32'h0000_0004);
    apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
    `CHK(rd_q, 32'h0000_0000)
    pend(3'b010);
    tk();
    @(posedge sys_clk_i);
    ppb_unpriv_i <= 1'b1;
    @(posedge sys_clk_i);
    `CHK(ppb_bus_error_o, 1'b1)
    ppb_unpriv_i <= 1'b0;
    apb(1'b0, BFSL_CFS_OFF, 32'h0, 4'h0);
    `CHK(rd_q, 32'h0000_0200)
    apb(1'b1, BFSL_CFS_OFF, 32'h0000_FF00, 4'h2);
    tk();
    u_resp.hit(BFSL_SRC_DATA, 1'b1, 32'h0000_0500);
    higher_pri_pending_i <= 1'b1;
    @(posedge sys_clk_i);
    `CHK(take_bus_fault_o, 1'b0)
    tk();
    pend(3'b001);
    higher_pri_pending_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK(take_bus_fault_o, 1'b1)
    tk();
    pend(3'b000);
    can_take_i <= 1'b0;
    u_resp.hit(BFSL_SRC_FETCH, 1'b0, 32'h0000_0600);
    pend(3'b010);
    `CHK(lockup_ok_o, 1'b1)
    tk();
    can_take_i <= 1'b1;
    apb(1'b1, BFSL_SHCS_OFF, 32'h0000_0000, 4'h4);
    u_resp.hit(BFSL_SRC_DATA, 1'b1, 32'h0000_0700);
    pend(3'b110);
    `CHK(lockup_ok_o, 1'b0)
    tally_and_finish();
  end
endmodule
